// >>> hdl/origin_return_sequencer.sv
// Homing sequencer with AXI4-Lite settings, pin inputs and speed command
// Assumes raw switch and index pins; speed_cmd feeds the velocity loop
// Functional notes
// R1 - Start source 0..4: off/input/keypad/comm/first-enable
// R2 - Patterns 0/1: fast search, limit is origin
// R3 - Patterns 2-5: home edge origin, 2/3 rise
// R4 - Patterns 6/7: nearest index pulse is origin
// R5 - Pattern 8: present position is origin
// R6 - Limit setting 0-2: reverse, then index choice
// R7 - Limit setting 3-5: stop and alarm
// R8 - Patterns 0/1 never alarm on limit
// R9 - Index search after limit or home edge
// R10 - Fast 1-3000 rpm, slow 1-300 rpm
// R11 - One ramp time 1-10000 ms
// R12 - Ignore start while busy; flag completion
`default_nettype none
module origin_return_sequencer #(
   parameter int MS_TICK_CYCLES = homing_pkg::MS_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [homing_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [homing_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic homing_start_input,
   input wire logic keypad_start_input,
   input wire logic servo_enable_input,
   input wire logic pos_limit_input,
   input wire logic neg_limit_input,
   input wire logic home_switch_input,
   input wire logic index_pulse_input,
   output logic [15:0] speed_cmd,
   output logic direction_forward,
   output logic origin_set,
   output logic homing_busy,
   output logic homing_done,
   output logic homing_alarm,
   output logic irq
);
   import homing_pkg::*;

   initial begin
      if (MS_TICK_CYCLES < 1) $error("MS_TICK_CYCLES must be positive");
   end

   homing_cfg_s cfg_reg;
   motion_pins_s pins;
   motion_pins_s pins_prev_reg;
   homing_state_e state_reg;
   logic [IRQ_W-1:0] irq_status_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_event;
   logic aw_got_reg;
   logic w_got_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_fire;
   logic rd_fire;
   logic comm_start_reg;
   logic first_enable_pending_reg;
   logic [15:0] target_reg;
   logic stop_alarm_reg;
   logic start_req;
   logic index_wanted_reg;
   logic [31:0] rd_value;
   logic rd_ok;
   logic wr_ok;
   logic limit_ahead;
   logic home_rise;
   logic home_fall;
   logic index_rise;
   logic enable_rise;
   logic [3:0] pat;
   logic [2:0] lim;

   pin_filter #(
      .WIDTH(PINS_W)
   ) u_pin_filter (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_async({servo_enable_input, keypad_start_input,
                  homing_start_input, pos_limit_input, neg_limit_input,
                  home_switch_input, index_pulse_input}),
      .pin_clean(pins)
   );

   speed_ramp #(
      .MS_TICK_CYCLES(MS_TICK_CYCLES)
   ) u_speed_ramp (
      .aclk(aclk),
      .aresetn(aresetn),
      .target(target_reg),
      .fast(cfg_reg.fast),
      .ramp_ms(cfg_reg.ramp), // R11
      .speed(speed_cmd)
   );

   assign pat = cfg_reg.pattern[3:0];
   assign lim = cfg_reg.limit[2:0];
   assign home_rise = pins.home_switch & ~pins_prev_reg.home_switch;
   assign home_fall = ~pins.home_switch & pins_prev_reg.home_switch;
   assign index_rise = pins.index_pulse & ~pins_prev_reg.index_pulse;
   assign enable_rise = pins.servo_enable & ~pins_prev_reg.servo_enable;
   assign limit_ahead = direction_forward ? pins.pos_limit : pins.neg_limit;

   // Start source selection
   always_comb begin
      case (trigger_e'(cfg_reg.trigger[2:0]))
         TRIG_INPUT: start_req = pins.start_input
            & ~pins_prev_reg.start_input; // R1
         TRIG_KEYPAD: start_req = pins.keypad_start
            & ~pins_prev_reg.keypad_start; // R1
         TRIG_COMM: start_req = comm_start_reg; // R1
         TRIG_FIRST_ENABLE: start_req = enable_rise
            & first_enable_pending_reg; // R1
         default: start_req = 1'b0; // R1
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_prev_reg <= '0;
      end else begin
         pins_prev_reg <= pins;
      end
   end

   // Only the first enable after power-up may start a run
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_enable_pending_reg <= 1'b1;
      end else if (enable_rise) begin
         first_enable_pending_reg <= 1'b0; // R1
      end
   end

   // Homing sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         target_reg <= 16'h0000;
         direction_forward <= 1'b1;
         origin_set <= 1'b0;
         homing_busy <= 1'b0;
         homing_done <= 1'b0;
         homing_alarm <= 1'b0;
         stop_alarm_reg <= 1'b0;
         index_wanted_reg <= 1'b0;
      end else begin
         origin_set <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               target_reg <= 16'h0000;
               if (start_req) begin
                  homing_done <= 1'b0;
                  homing_alarm <= 1'b0;
                  stop_alarm_reg <= 1'b0;
                  index_wanted_reg <= 1'b0;
                  if (pat == 4'h8) begin
                     origin_set <= 1'b1; // R5
                     homing_done <= 1'b1; // R12
                  end else if (pat >= 4'h6) begin
                     homing_busy <= 1'b1;
                     direction_forward <= (pat == 4'h6); // R4
                     target_reg <= cfg_reg.slow; // R10
                     state_reg <= ST_INDEX;
                  end else begin
                     homing_busy <= 1'b1;
                     direction_forward <= ~pat[0]; // R2 R3
                     target_reg <= cfg_reg.fast; // R10
                     state_reg <= ST_SEARCH;
                  end
               end
            end
            ST_SEARCH: begin
               if (pat <= 4'h1 && limit_ahead) begin
                  // Limit is the marker here; never an alarm
                  if (lim == 3'h2 || lim == 3'h5) begin // R8
                     origin_set <= 1'b1; // R2
                     target_reg <= 16'h0000;
                     state_reg <= ST_STOP;
                  end else begin
                     if (lim == 3'h0 || lim == 3'h3) begin
                        direction_forward <= ~direction_forward; // R9
                     end
                     target_reg <= cfg_reg.slow; // R9
                     state_reg <= ST_INDEX;
                  end
               end else if (pat >= 4'h2 && limit_ahead) begin
                  if (lim >= 3'h3) begin
                     stop_alarm_reg <= 1'b1; // R7
                     target_reg <= 16'h0000; // R7
                     state_reg <= ST_STOP;
                  end else begin
                     direction_forward <= ~direction_forward; // R6
                  end
               end else if ((pat <= 4'h3 && pat >= 4'h2 && home_rise)
                  || (pat >= 4'h4 && home_fall)) begin // R3
                  if (lim == 3'h2 || lim == 3'h5) begin
                     origin_set <= 1'b1; // R3
                     target_reg <= 16'h0000;
                     state_reg <= ST_STOP;
                  end else begin
                     if (lim == 3'h0 || lim == 3'h3) begin
                        direction_forward <= ~direction_forward; // R9
                     end
                     target_reg <= cfg_reg.slow; // R9
                     state_reg <= ST_INDEX;
                  end
               end
            end
            ST_INDEX: begin
               if (index_rise) begin
                  origin_set <= 1'b1; // R4 R9
                  target_reg <= 16'h0000;
                  state_reg <= ST_STOP;
               end else if (limit_ahead && pat >= 4'h6) begin
                  if (lim >= 3'h3) begin
                     stop_alarm_reg <= 1'b1; // R7
                     target_reg <= 16'h0000;
                     state_reg <= ST_STOP;
                  end else begin
                     direction_forward <= ~direction_forward; // R6
                  end
               end
            end
            ST_STOP: begin
               if (speed_cmd == 16'h0000) begin
                  homing_busy <= 1'b0;
                  homing_done <= ~stop_alarm_reg; // R12
                  homing_alarm <= stop_alarm_reg; // R7
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               target_reg <= 16'h0000;
               homing_busy <= 1'b0;
            end
         endcase
      end
   end

   // Events for the interrupt status
   assign irq_event[IRQ_DONE_BIT] = (state_reg == ST_STOP)
      && speed_cmd == 16'h0000 && !stop_alarm_reg
      || (state_reg == ST_IDLE && start_req && pat == 4'h8);
   assign irq_event[IRQ_ALARM_BIT] = (state_reg == ST_STOP)
      && speed_cmd == 16'h0000 && stop_alarm_reg;

   // AXI4-Lite write channel
   assign wr_fire = aw_got_reg && w_got_reg && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         waddr_reg <= '0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got_reg <= 1'b1;
            awready <= 1'b0;
            waddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_reg <= 1'b1;
            wready <= 1'b0;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   function automatic logic [15:0] clip(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      clip = (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction : clip

   always_comb begin
      case (waddr_reg)
         OFS_TRIGGER, OFS_PATTERN, OFS_LIMIT, OFS_FAST, OFS_SLOW,
            OFS_RAMP, OFS_CONTROL, OFS_IRQ_MASK: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Settings, held in range so the sequencer never sees a bad value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg <= {RST_TRIGGER, RST_PATTERN, RST_LIMIT, RST_FAST,
                     RST_SLOW, RST_RAMP};
         irq_mask_reg <= '0;
         comm_start_reg <= 1'b0;
      end else begin
         comm_start_reg <= 1'b0;
         if (wr_fire) begin
            case (waddr_reg)
               OFS_TRIGGER: cfg_reg.trigger <= clip(merge(cfg_reg.trigger,
                  wdata_reg, wstrb_reg), 16'h0000, TRIGGER_MAX); // R1
               OFS_PATTERN: cfg_reg.pattern <= clip(merge(cfg_reg.pattern,
                  wdata_reg, wstrb_reg), 16'h0000, PATTERN_MAX);
               OFS_LIMIT: cfg_reg.limit <= clip(merge(cfg_reg.limit,
                  wdata_reg, wstrb_reg), 16'h0000, LIMIT_MAX);
               OFS_FAST: cfg_reg.fast <= clip(merge(cfg_reg.fast,
                  wdata_reg, wstrb_reg), 16'h0001, FAST_MAX); // R10
               OFS_SLOW: cfg_reg.slow <= clip(merge(cfg_reg.slow,
                  wdata_reg, wstrb_reg), 16'h0001, SLOW_MAX); // R10
               OFS_RAMP: cfg_reg.ramp <= clip(merge(cfg_reg.ramp,
                  wdata_reg, wstrb_reg), 16'h0001, RAMP_MAX); // R11
               OFS_CONTROL: comm_start_reg <= wstrb_reg[0]
                  && wdata_reg[CTRL_COMM_START_BIT];
               OFS_IRQ_MASK: if (wstrb_reg[0]) begin
                  irq_mask_reg <= wdata_reg[IRQ_W-1:0];
               end
               default: ;
            endcase
         end
      end
   end

   // AXI4-Lite read channel
   assign rd_fire = arvalid && arready;

   always_comb begin
      rd_value = 32'h00000000;
      rd_ok = 1'b1;
      case (araddr)
         OFS_TRIGGER: rd_value[15:0] = cfg_reg.trigger;
         OFS_PATTERN: rd_value[15:0] = cfg_reg.pattern;
         OFS_LIMIT: rd_value[15:0] = cfg_reg.limit;
         OFS_FAST: rd_value[15:0] = cfg_reg.fast;
         OFS_SLOW: rd_value[15:0] = cfg_reg.slow;
         OFS_RAMP: rd_value[15:0] = cfg_reg.ramp;
         OFS_CONTROL: rd_value = 32'h00000000;
         OFS_STATUS: rd_value[7:0] = {state_reg, 1'b0, homing_alarm,
            homing_done, homing_busy};
         OFS_IRQ_STATUS: rd_value[IRQ_W-1:0] = irq_status_reg;
         OFS_IRQ_MASK: rd_value[IRQ_W-1:0] = irq_mask_reg;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end else begin
         if (rd_fire) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_value;
            rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // Sticky events, cleared by a read; a new event wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= '0;
      end else if (rd_fire && araddr == OFS_IRQ_STATUS) begin
         irq_status_reg <= irq_event;
      end else begin
         irq_status_reg <= irq_status_reg | irq_event;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end
endmodule : origin_return_sequencer
`default_nettype wire

// >>> hdl/pin_filter.sv
// Three-stage synchroniser for pins from outside the clock domain
// A change is taken once the second and third stages agree
`default_nettype none
module pin_filter #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_clean
);
   initial begin
      if (WIDTH < 1) $error("pin_filter: WIDTH must be at least 1");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            pin_clean[i] <= 1'b0;
         end else begin
            s1_reg <= pin_async[i];
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
               pin_clean[i] <= s3_reg;
            end
         end
      end
   end
endmodule : pin_filter
`default_nettype wire

// >>> hdl/speed_ramp.sv
// Speed ramp: moves the speed toward its target at the fast speed per ramp time
// Slope is the fast speed reached from zero in ramp_ms milliseconds
`default_nettype none
module speed_ramp #(
   parameter int MS_TICK_CYCLES = 25000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] target,
   input wire logic [15:0] fast,
   input wire logic [15:0] ramp_ms,
   output logic [15:0] speed
);
   import homing_pkg::*;

   logic [31:0] tick_cnt_reg;
   logic [31:0] acc_reg;
   logic tick;

   initial begin
      if (MS_TICK_CYCLES < 1) $error("speed_ramp: bad MS_TICK_CYCLES");
   end

   assign tick = (tick_cnt_reg == 32'(MS_TICK_CYCLES - 1));

   // Millisecond enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_reg <= 32'h00000000;
      end else if (tick) begin
         tick_cnt_reg <= 32'h00000000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
   end

   // Each ms adds the fast speed; each ramp_ms worth spent is one rpm step
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_reg <= 32'h00000000;
         speed <= 16'h0000;
      end else if (speed == target) begin
         acc_reg <= 32'h00000000;
      end else if (acc_reg >= {16'h0000, ramp_ms} && ramp_ms != 16'h0000) begin
         acc_reg <= acc_reg - {16'h0000, ramp_ms};
         speed <= (speed < target) ? speed + 16'h0001 : speed - 16'h0001;
      end else if (ramp_ms == 16'h0000) begin
         speed <= target;
      end else if (tick) begin
         acc_reg <= acc_reg + {16'h0000, fast};
      end
   end
endmodule : speed_ramp
`default_nettype wire

// >>> shared/homing_pkg.sv
// Shared constants, types and register map of the homing sequencer
// Assumes a 25 MHz control clock and an AXI4-Lite register bus
`default_nettype none
package homing_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_W = 6;

   localparam logic [ADDR_W-1:0] OFS_TRIGGER = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_PATTERN = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_LIMIT = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_FAST = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_SLOW = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_RAMP = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h24;

   localparam logic [15:0] RST_TRIGGER = 16'h0000;
   localparam logic [15:0] RST_PATTERN = 16'h0002;
   localparam logic [15:0] RST_LIMIT = 16'h0002;
   localparam logic [15:0] RST_FAST = 16'h01F4;
   localparam logic [15:0] RST_SLOW = 16'h0032;
   localparam logic [15:0] RST_RAMP = 16'h01F4;

   localparam logic [15:0] FAST_MAX = 16'h0BB8;
   localparam logic [15:0] SLOW_MAX = 16'h012C;
   localparam logic [15:0] RAMP_MAX = 16'h2710;
   localparam logic [15:0] TRIGGER_MAX = 16'h0004;
   localparam logic [15:0] PATTERN_MAX = 16'h0008;
   localparam logic [15:0] LIMIT_MAX = 16'h0005;

   localparam int CTRL_COMM_START_BIT = 0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ALARM_BIT = 1;
   localparam int IRQ_W = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      TRIG_OFF = 3'h0,
      TRIG_INPUT = 3'h1,
      TRIG_KEYPAD = 3'h2,
      TRIG_COMM = 3'h3,
      TRIG_FIRST_ENABLE = 3'h4
   } trigger_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SEARCH = 4'b0010,
      ST_INDEX = 4'b0100,
      ST_STOP = 4'b1000
   } homing_state_e;

   typedef struct packed {
      logic servo_enable;
      logic keypad_start;
      logic start_input;
      logic pos_limit;
      logic neg_limit;
      logic home_switch;
      logic index_pulse;
   } motion_pins_s;

   localparam int PINS_W = $bits(motion_pins_s);

   typedef struct packed {
      logic [15:0] trigger;
      logic [15:0] pattern;
      logic [15:0] limit;
      logic [15:0] fast;
      logic [15:0] slow;
      logic [15:0] ramp;
   } homing_cfg_s;
endpackage : homing_pkg
`default_nettype wire

// >>> tb/homing_props.sv
// Port checker for the homing sequencer
// Assumes a bind into origin_return_sequencer, one clock domain
`default_nettype none
module homing_props #(
   parameter int MS_TICK_CYCLES = 25000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [15:0] speed_cmd,
   input wire logic origin_set,
   input wire logic homing_busy,
   input wire logic homing_done,
   input wire logic homing_alarm
);
   timeunit 1ns;
   timeprecision 1ns;
   import homing_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_ans;
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("late bvalid");
   property p_rd_ans;
      arvalid && arready |=> rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("late rvalid");
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_spd_max;
      speed_cmd <= FAST_MAX;
   endproperty
   a_spd_max: assert property (p_spd_max) else $error("speed high");
   property p_idle_still;
      !homing_busy |-> speed_cmd == 16'h0000;
   endproperty
   a_idle_still: assert property (p_idle_still) else $error("idle move");
   property p_org_pulse;
      origin_set |=> !origin_set;
   endproperty
   a_org_pulse: assert property (p_org_pulse) else $error("long origin");
   property p_start_clr;
      $rose(homing_busy) |-> ##[0:1] !homing_done && !homing_alarm;
   endproperty
   a_start_clr: assert property (p_start_clr) else $error("stale flag");
   property p_excl;
      !(homing_done && homing_alarm);
   endproperty
   a_excl: assert property (p_excl) else $error("done with alarm");
   c_alarm: cover property ($rose(homing_alarm));
   c_origin: cover property (origin_set);
   c_done: cover property ($fell(homing_busy) && homing_done);
endmodule : homing_props
bind origin_return_sequencer homing_props #(
   .MS_TICK_CYCLES(MS_TICK_CYCLES)
) u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .speed_cmd,
   .origin_set, .homing_busy, .homing_done, .homing_alarm);
`default_nettype wire

// >>> tb/motion_model.sv
// Axis model: position, limit, home and index from the speed command
// Assumes one rpm moves one position unit per clock
`default_nettype none
module motion_model #(
   parameter int HOME_LO = 20000,
   parameter int HOME_HI = 30000,
   parameter int LIMIT = 60000,
   parameter int PITCH = 7000,
   parameter int INDEX_W = 1500
) (
   input wire logic aclk,
   input wire logic [15:0] speed_cmd,
   input wire logic direction_forward,
   output logic pos_limit_input,
   output logic neg_limit_input,
   output logic home_switch_input,
   output logic index_pulse_input
);
   timeunit 1ns;
   timeprecision 1ns;
   int pos = 0;
   always @(posedge aclk) begin
      pos <= direction_forward ? pos + int'(speed_cmd)
         : pos - int'(speed_cmd);
   end
   assign pos_limit_input = pos >= LIMIT;
   assign neg_limit_input = pos <= -LIMIT;
   assign home_switch_input = pos >= HOME_LO && pos < HOME_HI;
   // Offset keeps the modulo positive
   assign index_pulse_input = ((pos + 10 * LIMIT) % PITCH) < INDEX_W;
endmodule : motion_model
`default_nettype wire

// >>> tb/testbench.sv
// Bench: AXI4-Lite register checks and homing runs over all patterns
// Assumes motion_model as the axis and a shortened millisecond tick
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import homing_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
   logic rvalid, irq, homing_start_input = 0, keypad_start_input = 0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, resp, msk = 2'h3;
   logic servo_enable_input = 0, pos_limit_input, neg_limit_input;
   logic home_switch_input, index_pulse_input, direction_forward;
   logic origin_set, homing_busy, homing_done, homing_alarm;
   logic [15:0] speed_cmd;
   logic moved = 0, dir_seen = 0, pd = 0, pa = 0;
   int n_fail = 0, tests_run = 0, n_end = 0, n_org = 0;
   logic [15:0] rv [6] = '{RST_TRIGGER, RST_PATTERN, RST_LIMIT,
      RST_FAST, RST_SLOW, RST_RAMP};
   always #20 aclk = ~aclk;
   origin_return_sequencer #(.MS_TICK_CYCLES(4)) dut (.*);
   motion_model pm (.*);
   always @(posedge aclk) begin
      pd <= homing_done;
      pa <= homing_alarm;
      if ((homing_done && !pd) || (homing_alarm && !pa)
         || (origin_set && !homing_busy))
         n_end++;
      if (origin_set)
         n_org++;
      if (speed_cmd != 0 && !moved) begin
         moved = 1;
         dir_seen = direction_forward;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic aw = 0, w = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw = 1;
            awvalid <= 0;
         end
         if (wvalid && wready) begin
            w = 1;
            wvalid <= 0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      resp = bresp;
      bready <= 0;
   endtask : wr
   task automatic rc(input logic [5:0] a, input logic [31:0] exp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 0;
      chk(rd, exp);
      chk(resp, a > OFS_IRQ_MASK ? RESP_SLVERR : RESP_OKAY);
   endtask : rc
   task automatic wrc(input logic [5:0] a, input logic [31:0] d, e);
      wr(a, d);
      rc(a, e);
   endtask : wrc
   task automatic kick(input int src);
      @(posedge aclk);
      case (src)
         1: homing_start_input <= 1;
         2: keypad_start_input <= 1;
         4: servo_enable_input <= 1;
         default: wr(OFS_CONTROL, 32'h1);
      endcase
      repeat (6) @(posedge aclk);
      homing_start_input <= 0;
      keypad_start_input <= 0;
      repeat (6) @(posedge aclk);
   endtask : kick
   // ea: 0 done, 1 alarm, 2 never starts; ed: 0 rev, 1 fwd, 2 still
   task automatic run(input int t, p, l, src, pos, ea, ed);
      int e0, o0, i;
      #5 pm.pos = pos;
      wr(OFS_TRIGGER, t);
      wr(OFS_PATTERN, p);
      wr(OFS_LIMIT, l);
      moved = 0;
      e0 = n_end;
      o0 = n_org;
      kick(src);
      if (p != 8)
         kick(src);
      for (i = 0; i < 4000 && n_end == e0; i++)
         @(posedge aclk);
      chk(n_end - e0, ea < 2);
      if (ea < 2) begin
         chk(homing_alarm, ea);
         chk(homing_done, !ea);
         chk(n_org - o0, !ea);
         chk(moved ? dir_seen : 2, ed);
         repeat (3) @(posedge aclk);
         chk(irq, msk[ea]);
         rc(OFS_IRQ_STATUS, ea ? 32'h2 : 32'h1);
         repeat (3) @(posedge aclk);
         chk(irq, 0);
      end
   endtask : run
   task automatic print_verdict;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial begin
      #(40 * 90000);
      n_fail++;
      print_verdict;
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 6; i++)
         rc(6'(4 * i), rv[i]);
      rc(OFS_STATUS, 32'h10);
      rc(6'h3C, 32'h0);
      wr(6'h3C, 32'h1);
      chk(resp, RESP_SLVERR);
      wrc(OFS_FAST, 32'hFFFF, FAST_MAX);
      wrc(OFS_FAST, 32'h0, 32'h1);
      wrc(OFS_SLOW, 32'hFFFF, SLOW_MAX);
      wrc(OFS_RAMP, 32'hFFFF, RAMP_MAX);
      wrc(OFS_FAST, 32'h1F4, 32'h1F4);
      wrc(OFS_SLOW, 32'h32, 32'h32);
      wrc(OFS_RAMP, 32'h5, 32'h5);
      wr(OFS_IRQ_MASK, 32'h3);
      run(0, 2, 2, 1, 0, 2, 2);
      run(3, 8, 2, 3, 0, 0, 2);
      run(1, 2, 2, 1, 0, 0, 1);
      run(2, 3, 2, 2, 35000, 0, 0);
      run(1, 4, 2, 1, 25000, 0, 1);
      run(1, 5, 2, 1, 25000, 0, 0);
      run(1, 6, 2, 1, 3000, 0, 1);
      run(1, 7, 2, 1, 3000, 0, 0);
      run(1, 0, 0, 1, 0, 0, 1);
      run(1, 1, 5, 1, 0, 0, 0);
      run(1, 3, 5, 1, 0, 1, 0);
      run(1, 2, 1, 1, 35000, 0, 1);
      msk = 2'h2;
      wr(OFS_IRQ_MASK, 32'h2);
      run(4, 8, 2, 4, 0, 0, 2);
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
